// ==== logic/psw_top.sv ====
// Pin-selectable watchdog supervisor with an AXI4-Lite status port
`timescale 1ns/10ps
`default_nettype none
module psw_top
	import psw_pkg::*;
#(
	parameter logic [1:0] VARIANT = VAR_A, // Startup behaviour family
	parameter bit LONG_PULSE = 1'b1, // Long or short fault pulse
	parameter int unsigned TICK_CYC = TICK_CYC_DEF // Cycles per tick
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Supervised processor pins
	input wire logic kick_input_i,
	input wire logic timing_select_0_i,
	input wire logic timing_select_1_i,
	input wire logic timing_select_2_i,
	output logic fault_output_n_o,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read address
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	// Tick prescaler keeps the period counter narrow; shortening TICK_CYC
	// scales every period at once for simulation
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
	localparam logic [CNT_W-1:0] SETTLE_TICKS = to_ticks(SETTLE_US);
	localparam logic [CNT_W-1:0] PULSE_TICKS =
		to_ticks(LONG_PULSE ? PULSE_LONG_US : PULSE_SHORT_US);

	logic [PRE_W-1:0] pre_cnt; // Prescaler
	logic tick; // One-cycle tick enable
	logic [2:0] sel_a; // Select first stage
	logic [2:0] sel_b; // Select second stage
	logic [2:0] sel_cur; // Select code now in force
	logic sel_changed; // Pins differ from code in force
	logic kick_edge; // Qualified kick edge
	psw_state_t state; // Sequencer state
	psw_state_t next_state; // Sequencer next state
	logic [CNT_W-1:0] cnt; // Ticks spent in the current period
	logic [CNT_W-1:0] limit; // Length of the current period
	logic cnt_done; // Current period ends on this tick
	logic cnt_clear; // Restart the period counter
	logic [31:0] fault_count; // Fault pulses seen since last clear
	logic fault_cnt_clr; // Software clears the fault count
	logic aw_held; // Write address taken
	logic w_held; // Write data taken
	logic [3:0] aw_addr; // Latched write address

	////////////////////////////////////////////////////////////////////////
	// Kick qualifier
	psw_kick_qual u_kick (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.kick_input_i(kick_input_i),
		.edge_o(kick_edge)
	);

	////////////////////////////////////////////////////////////////////////
	// Prescaler: all periods are counted in ticks of the clock
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pre_cnt <= '0;
			tick <= 1'b0;
		end else if (pre_cnt == PRE_LAST) begin
			pre_cnt <= '0;
			tick <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Select pins synchronised before use
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_a <= '0;
			sel_b <= '0;
		end else begin
			sel_a <= {timing_select_2_i, timing_select_1_i,
				timing_select_0_i};
			sel_b <= sel_a;
		end
	end

	assign sel_changed = (sel_b != sel_cur);

	////////////////////////////////////////////////////////////////////////
	// Length of the period the counter is measuring
	always_comb begin
		unique case (state)
			ST_SETTLE: limit = SETTLE_TICKS;
			ST_STARTUP: limit = to_ticks(delay_us(VARIANT, sel_cur));
			ST_FAULT: limit = PULSE_TICKS;
			ST_RUN: limit = to_ticks(wd_us(VARIANT, sel_cur));
			default: limit = '0;
		endcase
	end

	assign cnt_done = tick && (cnt + 1'b1 >= limit);

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			ST_SETTLE: begin
				// Kicks are not looked at here
				if (sel_changed) begin
					next_state = ST_SETTLE;
				end else if (cnt_done) begin
					if (sel_cur == SEL_DISABLE) begin
						next_state = ST_DISABLED;
					end else if (VARIANT == VAR_C &&
						(sel_cur == SEL_FIRST_A || sel_cur == SEL_FIRST_B)) begin
						next_state = ST_FIRST_EDGE;
					end else begin
						next_state = ST_STARTUP;
					end
				end
			end
			ST_STARTUP: begin
				// Timed startup; kicks ignored, no fault
				if (sel_changed) begin
					next_state = ST_SETTLE;
				end else if (cnt_done) begin
					next_state = ST_RUN;
				end
			end
			ST_FIRST_EDGE: begin
				// No time limit; the first kick starts the countdown
				if (sel_changed) begin
					next_state = ST_SETTLE;
				end else if (kick_edge) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sel_changed) begin
					next_state = ST_SETTLE;
				end else if (cnt_done && !kick_edge) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				// The pulse always runs its full width, even after a change
				if (cnt_done) begin
					next_state = sel_changed ? ST_SETTLE : ST_RUN;
				end
			end
			ST_DISABLED: begin
				// Any other code re-enables through the settle time
				if (sel_changed) begin
					next_state = ST_SETTLE;
				end
			end
			default: next_state = ST_SETTLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state; reset enters the settle phase as at power-up
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= ST_SETTLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Code in force; during a fault the old code is kept until pulse end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_cur <= '0;
		end else if (state == ST_FAULT) begin
			if (cnt_done) begin
				sel_cur <= sel_b;
			end
		end else begin
			sel_cur <= sel_b;
		end
	end

	// Counter restarts on every state entry and on each kick in run; a
	// change seen during a fault stands until pulse end, so it must not
	// hold the pulse count at zero
	assign cnt_clear = (next_state != state) ||
		(sel_changed && state != ST_FAULT) ||
		(state == ST_RUN && kick_edge);

	////////////////////////////////////////////////////////////////////////
	// Period counter
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= '0;
		end else if (cnt_clear) begin
			cnt <= '0;
		end else if (tick && state != ST_DISABLED &&
			state != ST_FIRST_EDGE) begin
			cnt <= cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault output straight from a flop, low only in the fault state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_output_n_o <= 1'b1;
		end else begin
			fault_output_n_o <= (next_state != ST_FAULT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault counter; a fault in the cycle of a clear still counts
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_count <= '0;
		end else if (next_state == ST_FAULT && state != ST_FAULT) begin
			fault_count <= fault_cnt_clr ? 32'h1 : fault_count + 1'b1;
		end else if (fault_cnt_clr) begin
			fault_count <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	assign fault_cnt_clr = aw_held && w_held && !s_axi_bvalid_o &&
		aw_addr == ADDR_FAULTS;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid_o) begin
				// Any write to the fault count clears it; status is read only
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr == ADDR_STATUS ||
					aw_addr == ADDR_FAULTS) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel: one cycle from address to data
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= RESP_OKAY;
			s_axi_rdata_o <= '0;
			if (s_axi_araddr_i == ADDR_STATUS) begin
				s_axi_rdata_o[ST_SEL_LSB +: 3] <= sel_cur;
				s_axi_rdata_o[ST_STATE_LSB +: 3] <= state;
				s_axi_rdata_o[ST_FAULT_BIT] <= !fault_output_n_o;
			end else if (s_axi_araddr_i == ADDR_FAULTS) begin
				s_axi_rdata_o <= fault_count;
			end else begin
				// Unmapped: zero data with an error answer
				s_axi_rresp_o <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule // psw_top
`default_nettype wire

// ==== logic/psw_pkg.sv ====
// Constants, types and timing tables shared by the watchdog design files
`default_nettype none
package psw_pkg;

	// Clock and tick base
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_US = 10;
	localparam int unsigned TICK_CYC_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 26;
	localparam int unsigned PRE_W = 16;

	// Least kick pulse width, in ns and in cycles (rounded up)
	localparam int unsigned KICK_MIN_NS = 100;
	localparam int unsigned KICK_MIN_CYC =
		(KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KICK_CNT_W = 8;

	// Settle time after power-up or a select change
	localparam int unsigned SETTLE_US = 300;
	// Fault pulse widths for the long and the short builds
	localparam int unsigned PULSE_LONG_US = 100000;
	localparam int unsigned PULSE_SHORT_US = 1000;

	// Timing figures in microseconds
	localparam int unsigned T_30US = 30;
	localparam int unsigned T_200US = 200;
	localparam int unsigned T_1MS = 1000;
	localparam int unsigned T_3MS = 3000;
	localparam int unsigned T_10MS = 10000;
	localparam int unsigned T_30MS = 30000;
	localparam int unsigned T_100MS = 100000;
	localparam int unsigned T_300MS = 300000;
	localparam int unsigned T_1S = 1000000;
	localparam int unsigned T_3S = 3000000;
	localparam int unsigned T_10S = 10000000;
	localparam int unsigned T_60S = 60000000;

	// Variants: startup equals timeout, fixed startup, mixed table
	localparam logic [1:0] VAR_A = 2'h0;
	localparam logic [1:0] VAR_B = 2'h1;
	localparam logic [1:0] VAR_C = 2'h2;

	// Select codes with a special meaning
	localparam logic [2:0] SEL_DISABLE = 3'h3;
	localparam logic [2:0] SEL_FIRST_A = 3'h5;
	localparam logic [2:0] SEL_FIRST_B = 3'h6;

	// Register map (byte addresses) and fields
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_FAULTS = 4'h4;
	localparam int unsigned ST_SEL_LSB = 0;
	localparam int unsigned ST_STATE_LSB = 4;
	localparam int unsigned ST_FAULT_BIT = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Watchdog sequencing states
	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_STARTUP,
		ST_FIRST_EDGE,
		ST_RUN,
		ST_FAULT,
		ST_DISABLED
	} psw_state_t;

	// Microseconds to ticks, rounded up so least times are kept
	function automatic logic [CNT_W-1:0] to_ticks(input int unsigned us);
		return CNT_W'((us + TICK_US - 1) / TICK_US);
	endfunction

	// Timeout period for a variant and select code
	function automatic int unsigned wd_us(input logic [1:0] v,
		input logic [2:0] s);
		int unsigned a;
		int unsigned b;
		int unsigned c;
		a = 0;
		b = 0;
		c = 0;
		unique case (s)
			3'h0: begin a = T_1MS; b = T_1MS; c = T_3MS; end
			3'h1: begin a = T_10MS; b = T_3MS; c = T_3S; end
			3'h2: begin a = T_30MS; b = T_10MS; c = T_1S; end
			3'h3: begin a = 0; b = 0; c = 0; end
			3'h4: begin a = T_100MS; b = T_100MS; c = T_30US; end
			3'h5: begin a = T_1S; b = T_300MS; c = T_1S; end
			3'h6: begin a = T_10S; b = T_3S; c = T_10S; end
			3'h7: begin a = T_60S; b = T_60S; c = T_10S; end
		endcase
		return (v == VAR_A) ? a : (v == VAR_B) ? b : c;
	endfunction

	// Startup delay for a variant and select code
	function automatic int unsigned delay_us(input logic [1:0] v,
		input logic [2:0] s);
		int unsigned c;
		c = 0;
		unique case (s)
			3'h0: c = T_3MS;
			3'h1: c = T_3S;
			3'h2: c = T_60S;
			3'h4: c = T_200US;
			3'h7: c = T_60S;
			default: c = 0;
		endcase
		return (v == VAR_A) ? wd_us(v, s) : (v == VAR_B) ? T_60S : c;
	endfunction

endpackage
`default_nettype wire

// ==== logic/psw_kick_qual.sv ====
// Kick input synchroniser and least-width edge qualifier
`timescale 1ns/10ps
`default_nettype none
module psw_kick_qual
	import psw_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Raw kick pin
	input wire logic kick_input_i,
	// Qualified edge, one cycle
	output logic edge_o
);

	logic sync_a; // First stage, read only by sync_b
	logic sync_b; // Second stage
	logic level; // Last accepted level
	logic [KICK_CNT_W-1:0] hold_cnt; // Cycles the new level has stood

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= kick_input_i;
			sync_b <= sync_a;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A level must stand the least pulse width before it counts, so short
	// glitches never restart the timer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level <= 1'b0;
			hold_cnt <= '0;
			edge_o <= 1'b0;
		end else if (sync_b == level) begin
			// Back at the accepted level: drop the candidate
			hold_cnt <= '0;
			edge_o <= 1'b0;
		end else if (hold_cnt >= KICK_CNT_W'(KICK_MIN_CYC - 1)) begin
			// Wide enough: accept and flag the edge
			level <= sync_b;
			hold_cnt <= '0;
			edge_o <= 1'b1;
		end else begin
			hold_cnt <= hold_cnt + 1'b1;
			edge_o <= 1'b0;
		end
	end

endmodule // psw_kick_qual
`default_nettype wire

// ==== tb/psw_top_assertions.sv ====
// Port-level checks for the watchdog top module
`timescale 1ns/10ps
`default_nettype none
module psw_top_assertions
	import psw_pkg::*;
#(
	parameter logic [1:0] VARIANT = VAR_A, // Startup family
	parameter bit LONG_PULSE = 1'b1, // Long or short pulse
	parameter int unsigned TICK_CYC = TICK_CYC_DEF // Cycles per tick
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Watchdog pins
	input wire logic kick_input_i,
	input wire logic timing_select_0_i,
	input wire logic timing_select_1_i,
	input wire logic timing_select_2_i,
	input wire logic fault_output_n_o,
	// Write side
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// Read side
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	// Pulse and settle lengths in cycles
	localparam int unsigned PULSE_CYC =
		(LONG_PULSE ? PULSE_LONG_US : PULSE_SHORT_US) / TICK_US * TICK_CYC;
	localparam int unsigned SETTLE_CYC = SETTLE_US / TICK_US * TICK_CYC;
	logic [31:0] low_cnt; // Cycles the fault output has been low
	logic [31:0] up_cnt; // Cycles since reset, saturating
	logic [3:0] dis_cnt; // Cycles the pins have shown the disable code
	logic [2:0] pins; // Select pins as one code
	assign pins = {timing_select_2_i, timing_select_1_i, timing_select_0_i};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	////////////////////////////////////////////////////////////////////////
	// Counters for long spans; a repetition this long would unroll badly
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_cnt <= 32'h0;
			up_cnt <= 32'h0;
			dis_cnt <= 4'h0;
		end else begin
			low_cnt <= fault_output_n_o ? 32'h0 : low_cnt + 32'h1;
			if (up_cnt != 32'hffff)
				up_cnt <= up_cnt + 32'h1;
			if (pins != SEL_DISABLE)
				dis_cnt <= 4'h0;
			else if (dis_cnt != 4'hf)
				dis_cnt <= dis_cnt + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Bus handshake steps
	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid_o
		&& !s_axi_arready_o) else $error("read not answered");
	a_write_answer: assert property (wr_taken |=> !s_axi_awready_o
		##1 s_axi_bvalid_o) else $error("write not answered");
	a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read data dropped");
	a_unmapped_read: assert property (rd_taken ##0 (s_axi_araddr_i
		!= ADDR_STATUS && s_axi_araddr_i != ADDR_FAULTS)
		|=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read accepted");
	////////////////////////////////////////////////////////////////////////
	// Watchdog pin behaviour
	a_pulse_width: assert property (
		$rose(fault_output_n_o) |-> low_cnt >= PULSE_CYC - TICK_CYC
		&& low_cnt <= PULSE_CYC + TICK_CYC) else $error("bad pulse width");
	a_quiet_settle: assert property (
		!fault_output_n_o |-> up_cnt >= SETTLE_CYC)
		else $error("fault inside settle time");
	a_disable_quiet: assert property (
		$fell(fault_output_n_o) |-> dis_cnt < 4'h8)
		else $error("fault while disabled");
endmodule // psw_top_assertions
bind psw_top psw_top_assertions #(.VARIANT(VARIANT),
	.LONG_PULSE(LONG_PULSE), .TICK_CYC(TICK_CYC)) i_psw_chk (.*);
`default_nettype wire

// ==== tb/psw_cpu_model.sv ====
// Supervised processor model driving the kick and select pins
`timescale 1ns/10ps
`default_nettype none
module psw_cpu_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Commands from the bench
	input wire logic run_i,
	input wire logic [15:0] gap_i,
	input wire logic [2:0] code_i,
	// Pins toward the watchdog
	output logic kick_o,
	output logic [2:0] sel_o
);
	logic [15:0] cnt; // Cycles since the last kick level change
	logic [2:0] want; // Code to put on the pins next
	// A first-edge code is only reached through the disable code
	assign want = ((code_i == 3'h5 || code_i == 3'h6) && sel_o != code_i &&
		sel_o != 3'h3) ? 3'h3 : code_i;
	////////////////////////////////////////////////////////////////////////
	// Each level is held a whole gap, or over 16 cycles before a code move, never a narrow glitch, so a stuck
	// loop in the processor would stop the kicks
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			kick_o <= 1'b0;
			sel_o <= 3'h0;
			cnt <= 16'h0;
		end else if (want != sel_o) begin
			// Kick first if the level has stood over 16 cycles; move the code when the count reaches 16
			if (cnt > 16'h0010) begin
				kick_o <= ~kick_o;
				cnt <= 16'h0;
			end else begin
				cnt <= cnt + 16'h1;
			end
			if (cnt == 16'h0010)
				sel_o <= want;
		end else if (run_i && cnt >= gap_i) begin
			kick_o <= ~kick_o;
			cnt <= 16'h0;
		end else if (cnt != 16'hffff) begin
			cnt <= cnt + 16'h1;
		end
	end
endmodule // psw_cpu_model
`default_nettype wire

// ==== tb/test_pin_selectable_watchdog.sv ====
// Self-checking bench for the pin-selectable watchdog
`timescale 1ns/10ps
`default_nettype none
module test_pin_selectable_watchdog
	import psw_pkg::*;
;
	localparam int TC = 2; // Short tick keeps the run brief
	localparam int FW = PULSE_SHORT_US / TICK_US * TC; // Pulse cycles
	localparam int TO = T_1MS / TICK_US * TC; // Code 000 period
	localparam int ST = SETTLE_US / TICK_US * TC; // Settle cycles
	logic clk_i;
	logic rstn_i;
	logic run; // Processor kicks regularly
	logic [15:0] gap; // Cycles between kick edges
	logic [2:0] code; // Select code asked of the processor
	logic kick;
	logic [2:0] sel;
	logic fault_n;
	logic [3:0] awaddr;
	logic awvalid;
	logic awready;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [3:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0; // Cycle count for the hang limit
	int rel; // Cycle of reset release
	psw_cpu_model i_cpu (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(run),
		.gap_i(gap), .code_i(code), .kick_o(kick), .sel_o(sel));
	psw_top #(.VARIANT(VAR_A), .LONG_PULSE(1'b0), .TICK_CYC(TC)) i_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .kick_input_i(kick),
		.timing_select_0_i(sel[0]), .timing_select_1_i(sel[1]),
		.timing_select_2_i(sel[2]), .fault_output_n_o(fault_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(32'h0),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));
	////////////////////////////////////////////////////////////////////////
	// Checks and bus tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi,
		input string m);
		compares++;
		if (v < lo || v > hi) begin
			n_errors++;
			$display("unexpected at %0t: %s took %0d", $time, m, v);
		end
	endtask
	// The leading edge keeps back-to-back calls from driving twice at once
	task automatic rd(input logic [3:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		// Ready comes a cycle late so the read data must be held
		@(posedge clk_i);
		rready <= 1'b1;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		chk(rdata, ed, "read data");
		chk(32'(rresp), 32'(er), "read response");
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		fork
			begin
				do @(posedge clk_i); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge clk_i); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		// Ready only once the answer stands, so the response must be held
		do @(posedge clk_i); while (bvalid !== 1'b1);
		bready <= 1'b1;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er), "write response");
		bready <= 1'b0;
	endtask
	// Cycles until the fault pin shows the level asked for
	task automatic lvl(input logic v, output int n);
		n = 0;
		while (fault_n !== v) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	// Cycles in which the fault pin was not high
	task automatic quiet(input int c, output int n);
		n = 0;
		repeat (c) begin
			@(posedge clk_i);
			if (fault_n !== 1'b1)
				n++;
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clock and hang limit, well above the six thousand cycles needed
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int n;
		int t;
		rstn_i <= 1'b0;
		run <= 1'b0;
		gap <= 16'h0032;
		code <= 3'h0;
		awaddr <= 4'h0;
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b0;
		araddr <= 4'h0;
		arvalid <= 1'b0;
		rready <= 1'b0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		rel = cyc;
		rd(ADDR_STATUS, 32'h0, RESP_OKAY);
		rd(4'h8, 32'h0, RESP_SLVERR);
		wr(4'hc, RESP_SLVERR);
		$display("test registers done");
		// No kicks: startup, timeout, pulse, restart, change mid-pulse
		lvl(1'b0, n);
		rng(cyc - rel, ST + 2 * TO - 12, ST + 2 * TO + 12, "first");
		t = cyc;
		lvl(1'b1, n);
		rng(cyc - t, FW - TC, FW + TC, "pulse");
		lvl(1'b0, n);
		rng(n, TO - 4, TO + 4, "restart");
		t = cyc;
		rd(ADDR_STATUS, 32'h140, RESP_OKAY);
		code <= 3'h4;
		lvl(1'b1, n);
		rng(cyc - t, FW - TC, FW + TC, "changed pulse");
		rd(ADDR_STATUS, 32'h4, RESP_OKAY);
		rd(ADDR_FAULTS, 32'h2, RESP_OKAY);
		wr(ADDR_FAULTS, RESP_OKAY);
		rd(ADDR_FAULTS, 32'h0, RESP_OKAY);
		$display("test timeout done");
		// Regular kicks hold the fault off
		code <= 3'h0;
		run <= 1'b1;
		quiet(2500, n);
		chk(n, 0, "fault while kicked");
		rd(ADDR_STATUS, 32'h30, RESP_OKAY);
		$display("test kicks done");
		// Disable code, then re-enable without a reset
		code <= 3'h3;
		run <= 1'b0;
		quiet(1500, n);
		chk(n, 0, "fault while disabled");
		rd(ADDR_STATUS, 32'h53, RESP_OKAY);
		code <= 3'h0;
		t = cyc;
		lvl(1'b0, n);
		rng(cyc - t, ST + 2 * TO + 5, ST + 2 * TO + 30, "enable");
		$display("test disable done");
		stop_test();
	end
endmodule // test_pin_selectable_watchdog
`default_nettype wire
